// file: rtl/flash_cmd_defs.vh
// constants for the address-mode and soft-reset command interpreter
`ifndef FLASH_CMD_DEFS_VH
`define FLASH_CMD_DEFS_VH
// ==========================================================
// instruction codes
`define CMD_ENTER_WIDE_ADDR 8'hB7
`define CMD_RESET_ENABLE 8'h66
`define CMD_RESET 8'h99
// dedicated wide-address instructions (read, fast read, program, erase)
`define CMD_READ_WIDE 8'h13
`define CMD_FAST_READ_WIDE 8'h0C
`define CMD_PROGRAM_WIDE 8'h12
`define CMD_ERASE_WIDE 8'hDC
// ==========================================================
// discovery-table dword 16
`define DISC_DWORD16 32'hA1F830F0
`define DISC_DWORD16_OFFSET 8'h3C
`define DISC_ENTRY_LSB 24
`define DISC_RESET_LSB 8
`define DISC_RESET_FIELD 6'h30
`define DISC_RFU_BIT 7
// ==========================================================
// bus widths and resets
`define WIDTH_SINGLE 2'h0
`define WIDTH_DUAL 2'h1
`define WIDTH_QUAD 2'h2
`define ADDR_WIDE_RESET 1'b0
`define WIDE_ADDR_BYTES 3'h4
`define NARROW_ADDR_BYTES 3'h3
`endif

// file: rtl/flash_addr_mode_soft_reset.v
// command interpreter for address-width switching and the soft reset pair
`timescale 1ns/1ns
`default_nettype none
`include "flash_cmd_defs.vh"

module flash_addr_mode_soft_reset (
  input wire clk,
  input wire nrst,
  input wire csN, // chip select from pin, active low
  input wire sclk, // serial clock pin, sampled
  input wire [3:0] dqIn, // data wires in
  input wire [1:0] busWidth, // current interface width from mode logic
  input wire [7:0] discAddr, // discovery-table byte address
  output reg [7:0] discData, // discovery-table byte
  output reg wideAddr, // 32-bit addressing active
  output reg [2:0] addrBytes, // address bytes for current instruction
  output reg softReset, // one-cycle reset pulse to the device
  output reg resetArmed, // reset enable pending
  output reg cmdValid, // one-cycle pulse: instruction byte taken
  output reg [7:0] cmdByte // last instruction byte
);

// ==========================================================
// helpers
// true for instructions that carry a 32-bit address whatever the mode
function isWideCmd;
  input [7:0] c;
  begin
    isWideCmd = (c == `CMD_READ_WIDE) || (c == `CMD_FAST_READ_WIDE) ||
                (c == `CMD_PROGRAM_WIDE) || (c == `CMD_ERASE_WIDE);
  end
endfunction

// bits taken per serial clock at the given width
function [3:0] bitsPerClk;
  input [1:0] w;
  begin
    if (w == `WIDTH_QUAD) begin
      bitsPerClk = 4'h4;
    end else if (w == `WIDTH_DUAL) begin
      bitsPerClk = 4'h2;
    end else begin
      bitsPerClk = 4'h1;
    end
  end
endfunction

// ==========================================================
// pin synchronisers
reg [1:0] csSync; // chip select, two stages
reg [1:0] clkSync; // serial clock, two stages
reg [3:0] dqMeta; // data first stage
reg [3:0] dqSync; // data second stage
reg sclkLast; // previous synchronised clock for edge detect

// two flops per pin before anything looks at it
always @(posedge clk) begin
  if (!nrst) begin
    csSync <= 2'h3;
    clkSync <= 2'h0;
    dqMeta <= 4'h0;
    dqSync <= 4'h0;
    sclkLast <= 1'b0;
  end else begin
    csSync <= {csSync[0], csN};
    clkSync <= {clkSync[0], sclk};
    dqMeta <= dqIn;
    dqSync <= dqMeta;
    sclkLast <= clkSync[1];
  end
end

wire selected = ~csSync[1]; // device selected
wire sclkRise = clkSync[1] & ~sclkLast; // sampling edge, modes 0 and 3

// ==========================================================
// instruction shifter
reg [7:0] shiftReg; // instruction bits so far
reg [3:0] bitCount; // bits collected
reg gotCmd; // instruction of this frame already taken
reg [7:0] next_shift; // shifted value
reg [3:0] next_count; // count after this edge

// width follows the device's current mode so the reset pair decodes on 1/2/4 wires
always @* begin
  next_shift = shiftReg;
  next_count = bitCount + bitsPerClk(busWidth);
  if (busWidth == `WIDTH_QUAD) begin
    next_shift = {shiftReg[3:0], dqSync};
  end else if (busWidth == `WIDTH_DUAL) begin
    next_shift = {shiftReg[5:0], dqSync[1:0]};
  end else begin
    next_shift = {shiftReg[6:0], dqSync[0]};
  end
end

// collect the first byte of each frame; later bytes are address or data
always @(posedge clk) begin
  if (!nrst) begin
    shiftReg <= 8'h00;
    bitCount <= 4'h0;
    gotCmd <= 1'b0;
    cmdValid <= 1'b0;
    cmdByte <= 8'h00;
  end else begin
    cmdValid <= 1'b0;
    if (!selected) begin
      // deselect aborts a partial byte
      bitCount <= 4'h0;
      gotCmd <= 1'b0;
    end else if (sclkRise && !gotCmd) begin
      shiftReg <= next_shift;
      if (next_count >= 4'h8) begin
        cmdValid <= 1'b1;
        cmdByte <= next_shift;
        gotCmd <= 1'b1;
        bitCount <= 4'h0;
      end else begin
        bitCount <= next_count;
      end
    end
  end
end

// ==========================================================
// address mode and soft reset sequencer
localparam ST_IDLE = 2'b01; // no enable pending
localparam ST_ARMED = 2'b10; // reset enable taken
reg [1:0] state; // one-hot
reg resetPending; // 99h taken, fire at deselect

// instructions act once their byte is complete so a half-sent byte has no effect; the soft reset fires at deselect
always @(posedge clk) begin
  if (!nrst) begin
    // hardware reset or power-up returns to 24-bit addressing
    state <= ST_IDLE;
    wideAddr <= `ADDR_WIDE_RESET;
    addrBytes <= `NARROW_ADDR_BYTES;
    softReset <= 1'b0;
    resetArmed <= 1'b0;
    resetPending <= 1'b0;
  end else begin
    softReset <= 1'b0;
    if (resetPending && !selected) begin
      // completed soft reset also drops wide addressing
      resetPending <= 1'b0;
      softReset <= 1'b1;
      wideAddr <= `ADDR_WIDE_RESET;
      state <= ST_IDLE;
      resetArmed <= 1'b0;
    end else if (cmdValid) begin
      if (isWideCmd(cmdByte)) begin
        addrBytes <= `WIDE_ADDR_BYTES;
      end else begin
        addrBytes <= wideAddr ? `WIDE_ADDR_BYTES : `NARROW_ADDR_BYTES;
      end
      if (cmdByte == `CMD_ENTER_WIDE_ADDR) begin
        // no write-enable latch is consulted
        wideAddr <= 1'b1;
        addrBytes <= `WIDE_ADDR_BYTES;
      end
      case (state)
        ST_IDLE: begin
          if (cmdByte == `CMD_RESET_ENABLE) begin
            state <= ST_ARMED;
            resetArmed <= 1'b1;
          end
        end
        ST_ARMED: begin
          if (cmdByte == `CMD_RESET) begin
            resetPending <= 1'b1;
            state <= ST_IDLE;
            resetArmed <= 1'b0;
          end else if (cmdByte == `CMD_RESET_ENABLE) begin
            // a repeated enable simply stays armed
            state <= ST_ARMED;
          end else begin
            state <= ST_IDLE;
            resetArmed <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          resetArmed <= 1'b0;
        end
      endcase
    end
  end
end

// ==========================================================
// discovery-table dword, fixed content
wire [31:0] discWord = `DISC_DWORD16;
// check fields: reset support 110000b, bit 7 set
wire fieldsOk = (discWord[`DISC_RESET_LSB+5:`DISC_RESET_LSB] == `DISC_RESET_FIELD) &&
                discWord[`DISC_RFU_BIT];

// byte lanes, least significant at the lowest offset
always @(posedge clk) begin
  if (!nrst) begin
    discData <= 8'h00;
  end else if (discAddr == `DISC_DWORD16_OFFSET) begin
    discData <= fieldsOk ? discWord[7:0] : 8'hFF;
  end else if (discAddr == `DISC_DWORD16_OFFSET + 8'h01) begin
    discData <= discWord[15:8];
  end else if (discAddr == `DISC_DWORD16_OFFSET + 8'h02) begin
    discData <= discWord[23:16];
  end else if (discAddr == `DISC_DWORD16_OFFSET + 8'h03) begin
    discData <= discWord[31:`DISC_ENTRY_LSB];
  end else begin
    // other dwords live elsewhere
    discData <= 8'hFF;
  end
end

endmodule // flash_addr_mode_soft_reset
`default_nettype wire

// file: dv/flash_addr_mode_soft_reset_assertions.sv
// checker for the address-mode and soft-reset interpreter
`timescale 1ns/1ns
`default_nettype none
module flash_addr_mode_soft_reset_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic csN,
  input wire logic [7:0] discAddr,
  input wire logic [7:0] discData,
  input wire logic wideAddr,
  input wire logic [2:0] addrBytes,
  input wire logic softReset,
  input wire logic resetArmed,
  input wire logic cmdValid,
  input wire logic [7:0] cmdByte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========
  // command effects
  AST_WIDE: assert property (cmdValid && cmdByte == 8'hB7 |=> wideAddr) else $error("no wide mode");
  AST_DED: assert property (cmdValid && cmdByte == 8'h13 |=> addrBytes == 3'h4) else $error("short addr");
  AST_ARM: assert property (cmdValid && cmdByte == 8'h66 |=> resetArmed) else $error("not armed");
  AST_CANCEL: assert property (cmdValid && cmdByte != 8'h66 |=> !resetArmed) else $error("still armed");
  AST_SR_CS: assert property (softReset |-> csN) else $error("reset while selected");
  AST_SR_ONE: assert property (softReset |=> !softReset) else $error("long reset pulse");
  AST_SR_NARROW: assert property (softReset |-> ##[0:1] !wideAddr) else $error("wide after reset");
  // ==========
  // discovery bytes, one cycle behind the address
  AST_DISC_LO: assert property (discAddr == 8'h3C |=> discData == 8'hF0) else $error("bad byte 3C");
  AST_DISC_RST: assert property (discAddr == 8'h3D |=> discData == 8'h30) else $error("bad byte 3D");
  cover property (softReset);
  cover property ($rose(wideAddr));
  cover property (cmdValid && resetArmed);
endmodule // flash_addr_mode_soft_reset_chk
bind flash_addr_mode_soft_reset flash_addr_mode_soft_reset_chk i_chk (.clk, .nrst, .csN, .discAddr, .discData,
  .wideAddr, .addrBytes, .softReset, .resetArmed, .cmdValid, .cmdByte);
`default_nettype wire

// file: dv/flash_host_model.sv
// host controller model: chip select, slow serial clock, data wires
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
  input wire logic clk,
  output var logic csN,
  output var logic sclk,
  output var logic [3:0] dq
);
  initial csN = 1'b1;
  initial sclk = 1'b0;
  initial dq = 4'h0;
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // sclk rests low outside frames
  task automatic pulse(input logic [3:0] v);
    dq = v;
    tick(5);
    sclk = 1'b1;
    tick(5);
    sclk = 1'b0;
  endtask
  // released wires show the inverse so a stale value never reads true
  task automatic deselect;
    tick(5);
    csN = 1'b1;
    dq = ~dq;
    tick(10);
  endtask
  // one instruction byte, msb first
  task automatic send(input logic [7:0] b, input logic [1:0] w);
    int n;
    int i;
    logic [7:0] s;
    n = (w == 2'h2) ? 4 : (w == 2'h1) ? 2 : 1;
    tick(1);
    csN = 1'b0;
    for (i = 0; i < 8; i += n) begin
      s = b << i;
      pulse(n == 4 ? s[7:4] : n == 2 ? {2'h0, s[7:6]} : {3'h0, s[7]});
    end
    deselect();
  endtask
  // all ones for eight clocks ends continuous quad read
  task automatic exitQuad;
    tick(1);
    csN = 1'b0;
    repeat (8) pulse(4'hF);
    deselect();
  endtask
endmodule // flash_host_model
`default_nettype wire

// file: dv/flash_addr_mode_soft_reset_tb_top.sv
// testbench for the address-mode and soft-reset interpreter
`timescale 1ns/1ns
`default_nettype none
module flash_addr_mode_soft_reset_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] busWidth = 2'h0;
  logic [7:0] discAddr = 8'h00;
  wire csN;
  wire sclk;
  wire [3:0] dqIn;
  wire [7:0] discData;
  wire wideAddr;
  wire [2:0] addrBytes;
  wire softReset;
  wire resetArmed;
  wire cmdValid;
  wire [7:0] cmdByte;
  int failures = 0;
  int samples_checked = 0;
  int resets = 0;
  int cmds = 0; // instruction bytes taken so far
  always #20 clk = ~clk;
  always @(posedge clk) if (softReset === 1'b1) resets <= resets + 1;
  // every frame must yield exactly one instruction pulse
  always @(posedge clk) if (cmdValid === 1'b1) cmds <= cmds + 1;
  flash_host_model i_host (.clk(clk), .csN(csN), .sclk(sclk), .dq(dqIn));
  flash_addr_mode_soft_reset i_dut (.clk(clk), .nrst(nrst), .csN(csN), .sclk(sclk), .dqIn(dqIn),
    .busWidth(busWidth), .discAddr(discAddr), .discData(discData), .wideAddr(wideAddr), .addrBytes(addrBytes),
    .softReset(softReset), .resetArmed(resetArmed), .cmdValid(cmdValid), .cmdByte(cmdByte));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic frame(input logic [7:0] b, input logic [1:0] w);
    busWidth = w;
    i_host.send(b, w);
  endtask
  // ==========
  // scenarios
  task automatic t_disc;
    int i;
    for (i = 0; i < 5; i++) begin
      @(negedge clk) discAddr = 8'h3C + i[7:0];
      repeat (2) @(negedge clk);
      check(discData, i < 4 ? (32'hA1F830F0 >> (8 * i)) & 32'hFF : 32'hFF);
      if (i == 1) check(discData[5:0], 6'h30);
      if (i == 0) check(discData[7], 1'b1);
    end
    $display("test disc done");
  endtask
  task automatic t_addr;
    int c;
    c = cmds;
    frame(8'h13, 2'h0);
    check(addrBytes, 3'h4);
    frame(8'h05, 2'h0);
    check(addrBytes, 3'h3);
    frame(8'hB7, 2'h0);
    check(wideAddr, 1'b1);
    check(cmdByte, 8'hB7);
    // an ordinary instruction now carries four address bytes
    frame(8'h05, 2'h0);
    check(addrBytes, 3'h4);
    check(cmds - c, 4);
    $display("test addr done");
  endtask
  // one reset pair on every width, quad read left first
  task automatic t_reset;
    int w;
    for (w = 0; w < 3; w++) begin
      frame(8'hB7, w[1:0]);
      if (w == 2) i_host.exitQuad();
      frame(8'h66, w[1:0]);
      check(resetArmed, 1'b1);
      frame(8'h99, w[1:0]);
      check(cmdByte, 8'h99);
      check(wideAddr, 1'b0);
      check(resets, w + 1);
    end
    $display("test reset done");
  endtask
  task automatic t_cancel;
    frame(8'hB7, 2'h0);
    frame(8'h99, 2'h0);
    check(wideAddr, 1'b1);
    frame(8'h66, 2'h0);
    frame(8'h05, 2'h0);
    check(resetArmed, 1'b0);
    frame(8'h99, 2'h0);
    check(resets, 3);
    $display("test cancel done");
  endtask
  task automatic t_hw;
    nrst = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check(wideAddr, 1'b0);
    check(addrBytes, 3'h3);
    check(resetArmed, 1'b0);
    $display("test hw reset done");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t_disc();
    t_addr();
    t_reset();
    t_cancel();
    t_hw();
    summarize();
  end
  // far beyond the roughly 1600 cycles the tests take
  initial begin
    #800000;
    failures++;
    summarize();
  end
endmodule // flash_addr_mode_soft_reset_tb_top
`default_nettype wire
